// File: hdl/mx_defs.svh
`ifndef MX_DEFS_SVH
`define MX_DEFS_SVH

// Register byte offsets
`define MX_OFF_CMD 8'h00
`define MX_OFF_STATUS 8'h04
`define MX_OFF_CTRL 8'h08
`define MX_OFF_GPR 8'h0C
`define MX_OFF_SPR_LO 8'h10
`define MX_OFF_SPR_HI 8'h14
`define MX_OFF_SPTR 8'h18
`define MX_OFF_PC 8'h1C

// Status word bits
`define MX_SW0_EID 0
`define MX_SW0_IE 1
`define MX_SW1_C 0
`define MX_SW1_Z 1
`define MX_SW1_V 2
`define MX_SW1_N 3

// Special register indices
`define MX_SPR_SW0 3'h0
`define MX_SPR_SW1 3'h1
`define MX_SPR_IDH 3'h2
`define MX_SPR_IDL0 3'h3

// Control bits, status bits
`define MX_CTRL_WAKE 0
`define MX_CTRL_UNLOCK 1
`define MX_CTRL_CLRERR 2
`define MX_ST_BUSY 0
`define MX_ST_LOCK 1
`define MX_ST_ILL 2
`define MX_ST_CPUSTOP 3
`define MX_ST_SYSSTOP 4

// Constants of the instruction set
`define MX_IMM_STOP 8'h0A
`define MX_IMM_IDLE 8'h05
`define MX_HI_ZERO 8'h00
`define MX_PC_STEP 16'h0001
`define MX_PC_RST 16'h0000
`define MX_REG_RST 8'h00
`endif

// File: hdl/mx_pkg.sv
package mx_pkg;
   typedef enum logic [4:0]
   {
      MX_NOP = 5'h00, MX_BREAK = 5'h01, MX_SWAP = 5'h02, MX_PUSH_G = 5'h03,
      MX_PUSH_S = 5'h04, MX_POP_G = 5'h05, MX_POP_S = 5'h06, MX_POP2 = 5'h07,
      MX_SYS = 5'h08, MX_CLD_RD = 5'h09, MX_CLD_WR = 5'h0A, MX_COP = 5'h0B,
      MX_LDC = 5'h0C, MX_LD_TBL = 5'h0D, MX_LD_TBH = 5'h0E, MX_EI = 5'h0F,
      MX_DI = 5'h10, MX_SCF = 5'h11, MX_RCF = 5'h12, MX_ADD_DIR = 5'h13,
      MX_ADD_IMM = 5'h14, MX_ADD_REG = 5'h15, MX_ADD_IND = 5'h16,
      MX_ADC_DIR = 5'h17, MX_ADC_REG = 5'h18
   } mx_op_e;

   typedef enum logic [2:0]
   {
      MX_S_IDLE = 3'b001,
      MX_S_OPER = 3'b010,
      MX_S_EXEC = 3'b100
   } mx_state_e;

   // Command word, low 24 bits of a command write
   typedef struct packed {
      logic [11:0] imm;
      logic [2:0] special_reg;
      logic [1:0] src;
      logic [1:0] dst;
      mx_op_e op;
   } mx_cmd_s;

   // Coprocessor pins
   typedef struct packed {
      logic [11:0] code;
      logic [7:0] wdata;
      logic wr;
      logic svc_n;
      logic ld_n;
      logic ldw_n;
      logic cmd_n;
   } mx_cop_s;

   // Adder result with flags
   typedef struct packed {
      logic [7:0] sum;
      logic c;
      logic z;
      logic v;
      logic n;
   } mx_sum_s;
endpackage

// File: hdl/mx_adder.sv
`timescale 1ns/1ps

module mx_adder
(
   input logic [7:0] a,
   input logic [7:0] b,
   input logic cin,
   output mx_pkg::mx_sum_s res
);
   import mx_pkg::*;

   logic [8:0] wide;

   // Nine-bit sum keeps the carry-out
   assign wide = {1'h0, a} + {1'h0, b} + {8'h00, cin};
   assign res.sum = wide[7:0];
   assign res.c = wide[8];
   assign res.z = (wide[7:0] == 8'h00);
   assign res.v = (a[7] == b[7]) && (wide[7] != a[7]);
   assign res.n = res.v ^ wide[7];
endmodule

// File: hdl/mx_stack.sv
`timescale 1ns/1ps

module mx_stack
#(
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   input logic pclk,
   input logic presetn,
   input logic push,
   input logic pop1,
   input logic pop2,
   input logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic [AW-1:0] sptr
);
   import mx_pkg::*;

   logic [7:0] mem [0:DEPTH-1];
   logic [AW-1:0] below;

   // Entry just under the index
   assign below = sptr - AW'(1);
   assign rdata = mem[below];

   // Index moves after the access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sptr <= '0;
      else if (push)
         sptr <= sptr + AW'(1);
      else if (pop1)
         sptr <= sptr - AW'(1);
      else if (pop2)
         sptr <= sptr - AW'(2);
   end

   // Push writes the entry at the index
   always_ff @(posedge pclk)
   begin
      if (push)
         mem[sptr] <= wdata;
   end
endmodule

// File: hdl/mx_exec.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "mx_defs.svh"

module mx_exec
#(
   parameter int STACK_DEPTH = 16,
   parameter int STACK_AW = 4
)
(
   input logic pclk,
   input logic presetn,
   input logic [7:0] paddr,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output mx_pkg::mx_cop_s cop,
   input logic [7:0] cop_rdata,
   output logic [15:0] dmem_addr,
   output logic dmem_rd,
   input logic [7:0] dmem_rdata,
   output logic [19:0] pmem_addr,
   output logic pmem_rd,
   input logic [15:0] pmem_rdata,
   output logic cpu_clk_stop,
   output logic sys_clk_stop
);
   import mx_pkg::*;

   mx_state_e state;
   mx_state_e next_state;
   mx_cmd_s cmd;
   mx_cmd_s new_cmd;
   mx_cmd_s ecmd;
   mx_cop_s next_cop;
   mx_sum_s add_res;
   logic [7:0] general_reg [0:3];
   logic [7:0] special_reg [0:7];
   logic [7:0] table_high_latch;
   logic [7:0] table_low_latch;
   logic [15:0] pc;
   logic locked;
   logic illegal;
   logic [31:0] gpr_word;
   logic [63:0] spr_word;
   logic [7:0] stk_rdata;
   logic [STACK_AW-1:0] sptr;

   // APB phase decode
   wire setup = psel & ~penable;
   wire acc = psel & penable & pready;
   wire wr_acc = acc & pwrite & ~pslverr;
   wire busy = (state != MX_S_IDLE);
   wire halted = locked | cpu_clk_stop;

   // Address decode
   wire hit_cmd = (paddr == `MX_OFF_CMD);
   wire hit_status = (paddr == `MX_OFF_STATUS);
   wire hit_ctrl = (paddr == `MX_OFF_CTRL);
   wire hit_gpr = (paddr == `MX_OFF_GPR);
   wire hit_spr_lo = (paddr == `MX_OFF_SPR_LO);
   wire hit_spr_hi = (paddr == `MX_OFF_SPR_HI);
   wire hit_sptr = (paddr == `MX_OFF_SPTR);
   wire hit_pc = (paddr == `MX_OFF_PC);
   wire mapped = hit_cmd | hit_status | hit_ctrl | hit_gpr | hit_spr_lo | hit_spr_hi
      | hit_sptr | hit_pc;
   wire ro_hit = hit_status | hit_sptr | hit_pc;
   wire wr_refuse = pwrite & (ro_hit | (busy & ~hit_ctrl) | (hit_cmd & halted));
   wire next_err = ~mapped | wr_refuse;

   // Accepted writes
   wire cmd_go = wr_acc & hit_cmd;
   wire ctrl_wr = wr_acc & hit_ctrl;
   wire gpr_bus_wr = wr_acc & hit_gpr;
   wire spr_lo_wr = wr_acc & hit_spr_lo;
   wire spr_hi_wr = wr_acc & hit_spr_hi;

   // Command seen on entry and during execution
   assign new_cmd = mx_cmd_s'(pwdata[23:0]);
   assign ecmd = busy ? cmd : new_cmd;
   wire exec = (state == MX_S_EXEC);
   wire enter_exec = (next_state == MX_S_EXEC);
   wire need_dm = (new_cmd.op == MX_ADD_DIR) | (new_cmd.op == MX_ADD_IND)
      | (new_cmd.op == MX_ADC_DIR);
   wire need_pm = (new_cmd.op == MX_LDC);

   // Direct high byte follows the extended index bit
   wire [7:0] dir_hi = special_reg[`MX_SPR_SW0][`MX_SW0_EID] ? special_reg[`MX_SPR_IDH] : `MX_HI_ZERO;
   wire [15:0] next_daddr = (new_cmd.op == MX_ADD_IND) ?
      {special_reg[`MX_SPR_IDH], special_reg[`MX_SPR_IDL0]} : {dir_hi, new_cmd.imm[7:0]};
   wire [19:0] next_paddr = {general_reg[1][3:0], general_reg[2], general_reg[3]};

   // Sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         MX_S_IDLE:
         begin
            if (cmd_go)
               next_state = (need_dm | need_pm) ? MX_S_OPER : MX_S_EXEC;
         end
         MX_S_OPER: next_state = MX_S_EXEC;
         MX_S_EXEC: next_state = MX_S_IDLE;
         default: next_state = MX_S_IDLE;
      endcase
   end

   // Operation class of the executing command
   wire is_add = (cmd.op == MX_ADD_DIR) | (cmd.op == MX_ADD_IMM) | (cmd.op == MX_ADD_REG)
      | (cmd.op == MX_ADD_IND);
   wire is_adc = (cmd.op == MX_ADC_DIR) | (cmd.op == MX_ADC_REG);
   wire from_mem = (cmd.op == MX_ADD_DIR) | (cmd.op == MX_ADD_IND) | (cmd.op == MX_ADC_DIR);
   wire op_known = (cmd.op <= MX_ADC_REG);
   wire swap_bad = (cmd.op == MX_SWAP) & (cmd.special_reg <= `MX_SPR_SW1);
   wire ex_bad = exec & (swap_bad | ~op_known);

   // Adder operands
   wire [7:0] add_b = from_mem ? dmem_rdata :
      (cmd.op == MX_ADD_IMM) ? cmd.imm[7:0] : general_reg[cmd.src];
   wire add_cin = is_adc & special_reg[`MX_SPR_SW1][`MX_SW1_C];

   mx_adder u_adder
   (
      .a(general_reg[cmd.dst]),
      .b(add_b),
      .cin(add_cin),
      .res(add_res)
   );

   // Stack requests
   wire stk_push = exec & ((cmd.op == MX_PUSH_G) | (cmd.op == MX_PUSH_S));
   wire stk_pop1 = exec & ((cmd.op == MX_POP_G) | (cmd.op == MX_POP_S));
   wire stk_pop2 = exec & (cmd.op == MX_POP2);
   wire [7:0] stk_wdata = (cmd.op == MX_PUSH_G) ? general_reg[cmd.dst] : special_reg[cmd.special_reg];

   mx_stack #(.DEPTH(STACK_DEPTH), .AW(STACK_AW)) u_stack
   (
      .pclk(pclk),
      .presetn(presetn),
      .push(stk_push),
      .pop1(stk_pop1),
      .pop2(stk_pop2),
      .wdata(stk_wdata),
      .rdata(stk_rdata),
      .sptr(sptr)
   );

   // General register write port
   wire gpr_we = exec & ((cmd.op == MX_SWAP) & ~swap_bad | (cmd.op == MX_POP_G)
      | (cmd.op == MX_CLD_RD) | (cmd.op == MX_LD_TBL) | (cmd.op == MX_LD_TBH)
      | is_add | is_adc);
   wire [7:0] gpr_wdata = (cmd.op == MX_SWAP) ? special_reg[cmd.special_reg] :
      (cmd.op == MX_POP_G) ? stk_rdata :
      (cmd.op == MX_CLD_RD) ? cop_rdata :
      (cmd.op == MX_LD_TBL) ? table_low_latch :
      (cmd.op == MX_LD_TBH) ? table_high_latch : add_res.sum;

   // Flags after an add
   wire [7:0] add_flags = {special_reg[`MX_SPR_SW1][7:4], add_res.n, add_res.v, add_res.z,
      add_res.c};

   // Special register write port
   wire spr_we = exec & ((cmd.op == MX_SWAP) & ~swap_bad | (cmd.op == MX_POP_S)
      | (cmd.op == MX_EI) | (cmd.op == MX_DI) | (cmd.op == MX_SCF) | (cmd.op == MX_RCF)
      | is_add | is_adc);
   wire on_sw0 = (cmd.op == MX_EI) | (cmd.op == MX_DI);
   wire on_sw1 = (cmd.op == MX_SCF) | (cmd.op == MX_RCF) | is_add | is_adc;
   wire [2:0] spr_widx = on_sw0 ? `MX_SPR_SW0 : on_sw1 ? `MX_SPR_SW1 : cmd.special_reg;
   wire [7:0] sw0_ie_set = special_reg[`MX_SPR_SW0] | (8'h01 << `MX_SW0_IE);
   wire [7:0] sw0_ie_clr = special_reg[`MX_SPR_SW0] & ~(8'h01 << `MX_SW0_IE);
   wire [7:0] sw1_c_set = special_reg[`MX_SPR_SW1] | (8'h01 << `MX_SW1_C);
   wire [7:0] sw1_c_clr = special_reg[`MX_SPR_SW1] & ~(8'h01 << `MX_SW1_C);
   wire [7:0] spr_wdata = (cmd.op == MX_SWAP) ? general_reg[cmd.dst] :
      (cmd.op == MX_POP_S) ? stk_rdata :
      (cmd.op == MX_EI) ? sw0_ie_set :
      (cmd.op == MX_DI) ? sw0_ie_clr :
      (cmd.op == MX_SCF) ? sw1_c_set :
      (cmd.op == MX_RCF) ? sw1_c_clr : add_flags;

   // Coprocessor strobes for the coming execute cycle
   wire e_sys = enter_exec & (ecmd.op == MX_SYS);
   wire e_cld = enter_exec & ((ecmd.op == MX_CLD_RD) | (ecmd.op == MX_CLD_WR));
   wire e_cop = enter_exec & (ecmd.op == MX_COP);
   always_comb
   begin
      next_cop = cop;
      next_cop.svc_n = ~e_sys;
      next_cop.ld_n = ~e_cld;
      next_cop.ldw_n = ~e_cld;
      next_cop.cmd_n = ~e_cop;
      if (e_sys | e_cld)
         next_cop.code = {4'h0, ecmd.imm[7:0]};
      else if (e_cop)
         next_cop.code = ecmd.imm;
      if (e_cld)
         next_cop.wr = (ecmd.op == MX_CLD_WR);
      if (e_cld & (ecmd.op == MX_CLD_WR))
         next_cop.wdata = general_reg[ecmd.dst];
   end

   // Power-saving entry
   wire sys_ex = exec & (cmd.op == MX_SYS);
   wire go_stop = sys_ex & (cmd.imm[7:0] == `MX_IMM_STOP);
   wire go_idle = sys_ex & (cmd.imm[7:0] == `MX_IMM_IDLE);
   wire wake = ctrl_wr & pwdata[`MX_CTRL_WAKE];

   // Read data mux
   wire [31:0] status_word = {27'h0000000, sys_clk_stop, cpu_clk_stop, illegal, locked, busy};
   wire [31:0] rd_mux = hit_cmd ? {8'h00, cmd} :
      hit_status ? status_word :
      hit_gpr ? gpr_word :
      hit_spr_lo ? spr_word[31:0] :
      hit_spr_hi ? spr_word[63:32] :
      hit_sptr ? {{(32 - STACK_AW){1'h0}}, sptr} :
      hit_pc ? {16'h0000, pc} : 32'h00000000;

   // Packed register views
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_view
         if (gi < 4)
         begin : g_gpr
            assign gpr_word[8*gi +: 8] = general_reg[gi];
         end
         assign spr_word[8*gi +: 8] = special_reg[gi];
      end
   endgenerate

   // APB answer, no wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'h0;
         pslverr <= 1'h0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & next_err;
         if (setup)
            prdata <= (pwrite | ~mapped) ? 32'h00000000 : rd_mux;
      end
   end

   // Sequencer state and memory requests
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= MX_S_IDLE;
         cmd <= '0;
         dmem_rd <= 1'h0;
         pmem_rd <= 1'h0;
         dmem_addr <= 16'h0000;
         pmem_addr <= 20'h00000;
         cop <= '{code: 12'h000, wdata: 8'h00, wr: 1'h0, svc_n: 1'h1, ld_n: 1'h1,
            ldw_n: 1'h1, cmd_n: 1'h1};
      end
      else
      begin
         state <= next_state;
         cop <= next_cop;
         dmem_rd <= cmd_go & need_dm;
         pmem_rd <= cmd_go & need_pm;
         if (cmd_go)
         begin
            cmd <= new_cmd;
            dmem_addr <= next_daddr;
            pmem_addr <= next_paddr;
         end
      end
   end

   // Register file
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 4; i++)
            general_reg[i] <= `MX_REG_RST;
         for (int i = 0; i < 8; i++)
            special_reg[i] <= `MX_REG_RST;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
            if (gpr_bus_wr)
               general_reg[i] <= pwdata[8*i +: 8];
         for (int i = 0; i < 4; i++)
         begin
            if (spr_lo_wr)
               special_reg[i] <= pwdata[8*i +: 8];
            if (spr_hi_wr)
               special_reg[i+4] <= pwdata[8*i +: 8];
         end
         if (gpr_we)
            general_reg[cmd.dst] <= gpr_wdata;
         if (spr_we)
            special_reg[spr_widx] <= spr_wdata;
      end
   end

   // Program counter, table latches, lock and error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc <= `MX_PC_RST;
         table_high_latch <= `MX_REG_RST;
         table_low_latch <= `MX_REG_RST;
         locked <= 1'h0;
         illegal <= 1'h0;
      end
      else
      begin
         if (exec & ~ex_bad & (cmd.op != MX_BREAK))
            pc <= pc + `MX_PC_STEP;
         if (exec & (cmd.op == MX_LDC))
         begin
            table_high_latch <= pmem_rdata[15:8];
            table_low_latch <= pmem_rdata[7:0];
         end
         locked <= (locked & ~(ctrl_wr & pwdata[`MX_CTRL_UNLOCK]))
            | (exec & (cmd.op == MX_BREAK));
         illegal <= (illegal & ~(ctrl_wr & pwdata[`MX_CTRL_CLRERR])) | ex_bad;
      end
   end

   // Clock stop requests
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_clk_stop <= 1'h0;
         sys_clk_stop <= 1'h0;
      end
      else
      begin
         cpu_clk_stop <= (cpu_clk_stop & ~wake) | go_stop | go_idle;
         sys_clk_stop <= (sys_clk_stop & ~wake) | go_stop;
      end
   end
endmodule

// File: test/mx_cop_model.sv
`timescale 1ns/1ps

module mx_cop_model
(
   input logic pclk,
   input mx_pkg::mx_cop_s cop,
   output logic [7:0] cop_rdata,
   input logic [15:0] dmem_addr,
   input logic dmem_rd,
   output logic [7:0] dmem_rdata,
   input logic [19:0] pmem_addr,
   input logic pmem_rd,
   output logic [15:0] pmem_rdata
);
   import mx_pkg::*;
   logic [7:0] mem [256];
   logic [7:0] junk = 8'hA5;
   logic dvalid = 1'b0;
   logic pvalid = 1'b0;

   // Changing filler and the one-cycle memory latency
   always @(posedge pclk)
   begin
      junk <= junk + 8'h3B;
      dvalid <= dmem_rd;
      pvalid <= pmem_rd;
      if (!cop.ld_n && cop.wr)
         mem[cop.code[7:0]] <= cop.wdata;
   end

   // Data only in its valid cycle, filler otherwise
   assign cop_rdata = (!cop.ld_n && !cop.wr) ? mem[cop.code[7:0]] : junk;
   assign dmem_rdata = dvalid ? dmem_addr[7:0] + dmem_addr[15:8] : ~junk;
   assign pmem_rdata = pvalid ? {pmem_addr[7:0], ~pmem_addr[7:0]} : {junk, junk};
endmodule

// File: test/mx_exec_chk.sv
`timescale 1ns/1ps

module mx_exec_chk
(
   input logic pclk,
   input logic presetn,
   input logic [7:0] paddr,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] pwdata,
   input logic pready,
   input mx_pkg::mx_cop_s cop,
   input logic cpu_clk_stop,
   input logic sys_clk_stop
);
   import mx_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Strobes follow the accepted command word
   property p_svc_code;
      $fell(cop.svc_n) |-> cop.code == {4'h0, $past(pwdata[19:12])};
   endproperty
   a_svc_code: assert property (p_svc_code) else $error("service code wrong");
   property p_cmd_code;
      $fell(cop.cmd_n) |-> cop.code == $past(pwdata[23:12]);
   endproperty
   a_cmd_code: assert property (p_cmd_code) else $error("command code wrong");
   property p_cmd_cause;
      $fell(cop.cmd_n) |-> $past(psel && penable && pready && pwrite && paddr == 8'h00);
   endproperty
   a_cmd_cause: assert property (p_cmd_cause) else $error("strobe without command");
   property p_ld_pair;
      $fell(cop.ld_n) |-> !cop.ldw_n ##1 (cop.ld_n && cop.ldw_n);
   endproperty
   a_ld_pair: assert property (p_ld_pair) else $error("load strobes not paired");
   property p_ld_dir;
      $fell(cop.ld_n) |-> cop.wr == ($past(pwdata[4:0]) == 5'h0A);
   endproperty
   a_ld_dir: assert property (p_ld_dir) else $error("load direction wrong");
   property p_stop;
      $fell(cop.svc_n) && cop.code[7:0] == 8'h0A |=> cpu_clk_stop && sys_clk_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("deep stop missing");
   property p_idle;
      $fell(cop.svc_n) && cop.code[7:0] == 8'h05 |=> cpu_clk_stop && !sys_clk_stop;
   endproperty
   a_idle: assert property (p_idle) else $error("light stop wrong");
   property p_excl;
      $onehot0({!cop.svc_n, !cop.ld_n, !cop.cmd_n});
   endproperty
   a_excl: assert property (p_excl) else $error("two strobes at once");

   // Main scenarios reached
   c_svc: cover property ($fell(cop.svc_n));
   c_ld: cover property ($fell(cop.ld_n));
   c_cmd: cover property ($fell(cop.cmd_n));
endmodule

bind mx_exec mx_exec_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
   .pwdata, .pready, .cop, .cpu_clk_stop, .sys_clk_stop);

// File: test/misc_and_add_instr_exec_tb_top.sv
`timescale 1ns/1ps

module misc_and_add_instr_exec_tb_top;
   import mx_pkg::*;
   typedef struct packed {
      logic [31:0] g0, s0, cmd, g1, s1;
      logic adv;
   } mx_row_s;
   localparam mx_row_s ROWS [15] = '{
      '{32'h17F00, 32'h0, 32'h135, 32'h18000, 32'h400, 1'b1},
      '{32'h1, 32'h0, 32'hFF014, 32'h0, 32'h300, 1'b1},
      '{32'h8080, 32'h100, 32'h98, 32'h8001, 32'hD00, 1'b1},
      '{32'hFF, 32'h100, 32'h98, 32'h0, 32'h300, 1'b1},
      '{32'h1, 32'h0, 32'h80013, 32'h81, 32'h800, 1'b1},
      '{32'h5, 32'h800101, 32'h80017, 32'h6, 32'h800001, 1'b1},
      '{32'h10, 32'h34120000, 32'h16, 32'h56, 32'h34120000, 1'b1},
      '{32'h8, 32'hF00, 32'h402, 32'h0, 32'h80F00, 1'b1},
      '{32'h8, 32'hF00, 32'h202, 32'h8, 32'hF00, 1'b0},
      '{32'h0, 32'h0, 32'hF, 32'h0, 32'h2, 1'b1},
      '{32'h0, 32'h3, 32'h10, 32'h0, 32'h1, 1'b1},
      '{32'h0, 32'hE00, 32'h11, 32'h0, 32'hF00, 1'b1},
      '{32'h0, 32'hF00, 32'h12, 32'h0, 32'hE00, 1'b1},
      '{32'h5A, 32'h0, 32'h0, 32'h5A, 32'h0, 1'b1},
      '{32'h5A, 32'h0, 32'h1F, 32'h5A, 32'h0, 1'b0}};
   localparam logic [7:0] STOPS [2] = '{8'h05, 8'h0A};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, dmem_rd, pmem_rd, cpu_clk_stop, sys_clk_stop;
   mx_cop_s cop;
   logic [7:0] cop_rdata, dmem_rdata;
   logic [15:0] dmem_addr, pmem_rdata;
   logic [19:0] pmem_addr;
   logic [15:0] pc_exp = 16'h0;
   int mismatches = 0;
   int samples_checked = 0;

   // Device, far-side model, clock
   mx_exec DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .cop, .cop_rdata, .dmem_addr, .dmem_rd, .dmem_rdata, .pmem_addr,
      .pmem_rd, .pmem_rdata, .cpu_clk_stop, .sys_clk_stop);
   mx_cop_model u_cop (.pclk, .cop, .cop_rdata, .dmem_addr, .dmem_rd, .dmem_rdata,
      .pmem_addr, .pmem_rd, .pmem_rdata);
   always #50 pclk = ~pclk;

   task automatic final_report();
      $display("Checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One bus transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         mismatches++;
         final_report();
      end
   endtask

   task automatic cmd(input logic [31:0] c);
      apb(1'b1, 8'h00, c);
      @(negedge pclk);
   endtask

   task automatic idle();
      int n;
      n = 0;
      do
      begin
         apb(1'b0, 8'h04, 32'h0);
         n++;
      end
      while (rdat[0] !== 1'b0 && n < 10);
      check("busy", {31'h0, rdat[0]}, 32'h0);
      if (rdat[0] !== 1'b0)
         final_report();
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(posedge pclk);
      check("rst", {26'h0, cop.svc_n, cop.ld_n, cop.ldw_n, cop.cmd_n, cpu_clk_stop,
         sys_clk_stop}, 32'h3C);
      presetn <= 1'b1;
      foreach (ROWS[i])
      begin
         apb(1'b1, 8'h0C, ROWS[i].g0);
         apb(1'b1, 8'h10, ROWS[i].s0);
         cmd(ROWS[i].cmd);
         idle();
         pc_exp += {15'h0, ROWS[i].adv};
         apb(1'b0, 8'h0C, 32'h0);
         check("gpr", rdat, ROWS[i].g1);
         apb(1'b0, 8'h10, 32'h0);
         check("spr", rdat, ROWS[i].s1);
         apb(1'b0, 8'h1C, 32'h0);
         check("pc", rdat, {16'h0, pc_exp});
      end
      apb(1'b0, 8'h04, 32'h0);
      check("ill", {29'h0, rdat[2:0]}, 32'h4);
      apb(1'b1, 8'h08, 32'h4);
      cmd(32'h01);
      apb(1'b0, 8'h1C, 32'h0);
      check("brk", rdat, {16'h0, pc_exp});
      cmd(32'h0);
      check("lock", {31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h08, 32'h2);
      apb(1'b1, 8'h0C, 32'h8);
      cmd(32'h03);
      apb(1'b0, 8'h18, 32'h0);
      check("push", rdat, 32'h1);
      cmd(32'h25);
      apb(1'b0, 8'h0C, 32'h0);
      check("pop", rdat, 32'h808);
      cmd(32'h03);
      cmd(32'h03);
      cmd(32'h07);
      apb(1'b0, 8'h18, 32'h0);
      check("pop2", rdat, 32'h0);
      apb(1'b1, 8'h0C, 32'hA5);
      cmd(32'h4400A);
      check("cldw", {7'h0, cop}, {7'h0, 12'h044, 8'hA5, 5'b11001});
      cmd(32'h44049);
      apb(1'b0, 8'h0C, 32'h0);
      check("cldr", rdat, 32'hA500A5);
      cmd(32'hABC00B);
      check("cop", {16'h0, cop.code, cop.svc_n, cop.ld_n, cop.ldw_n, cop.cmd_n},
         {16'h0, 12'hABC, 4'b1110});
      apb(1'b1, 8'h0C, 32'h34120100);
      cmd(32'h0C);
      idle();
      cmd(32'h0D);
      cmd(32'h2E);
      apb(1'b0, 8'h0C, 32'h0);
      check("tbl", rdat, 32'h341234CB);
      for (int i = 0; i < 2; i++)
      begin
         cmd({12'h000, STOPS[i], 12'h008});
         check("sys", {16'h0, cop.code, cop.svc_n, cop.ld_n, cop.ldw_n, cop.cmd_n},
            {16'h0, 4'h0, STOPS[i], 4'b0111});
         apb(1'b0, 8'h04, 32'h0);
         check("stop", {28'h0, rdat[4:3], sys_clk_stop, cpu_clk_stop},
            (i == 0) ? 32'h5 : 32'hF);
         cmd(32'h0);
         check("held", {31'h0, rerr}, 32'h1);
         apb(1'b1, 8'h08, 32'h1);
      end
      apb(1'b0, 8'h20, 32'h0);
      check("unmap", {rerr, rdat[30:0]}, 32'h80000000);
      apb(1'b1, 8'h04, 32'h1);
      check("ro", {31'h0, rerr}, 32'h1);
      final_report();
   end
endmodule
